// File: hw/irm_map_cfg.svh
// constants for the internal ram map, size limit and core i/o decode
`ifndef IRM_MAP_CFG_SVH
`define IRM_MAP_CFG_SVH

// ----------------------------------------------------------------
// address space and embedded ram
// ----------------------------------------------------------------
`define IRM_ADDR_W        28
`define IRM_RAM_WORDS     2048
`define IRM_RAM_IDX_W     11
`define IRM_RAM_LIM_8K    28'h0002000
`define IRM_RAM_LIM_4K    28'h0001000
`define IRM_RAM_LIM_2K    28'h0000800
`define IRM_DBG_TAIL      28'h0000040

// ----------------------------------------------------------------
// size register layout
// ----------------------------------------------------------------
`define IRM_SIZE_IDX      28'h0005326
`define IRM_KEY_IDX       28'h0005324
`define IRM_SZ_8K         3'h1
`define IRM_SZ_4K         3'h2
`define IRM_SZ_2K         3'h3
`define IRM_SZ_RESET      3'h1
`define IRM_SZ_LSB        0
`define IRM_SZ_MSB        2
`define IRM_RSV_LSB       4
`define IRM_RSV_MSB       6
`define IRM_RSV_VALUE     3'h1
`define IRM_DBSEL_BIT     8
`define IRM_DBSEL_RESET   1'h0
`define IRM_KEY_VALUE     8'h96
`define IRM_KEY_RESET     8'h00
`define IRM_DBG_BASE_HI   24'hFFC00
`define IRM_DBG_BASE_LO   24'h00000

// ----------------------------------------------------------------
// display memory and peripheral regions
// ----------------------------------------------------------------
`define IRM_DISP_BASE     28'h00053C0
`define IRM_DISP_BYTES    28'h0000038
`define IRM_DISP_WORDS    14
`define IRM_DISP_IDX_W    4
`define IRM_P1_BASE       28'h0004000
`define IRM_P1_SIZE       28'h0000400
`define IRM_P2_BASE       28'h0005000
`define IRM_P2_SIZE       28'h0001000
`define IRM_P1_WIDE       32'hFFFFFF00
`define IRM_P2_WIDE       32'hFFFFFFC0

// ----------------------------------------------------------------
// core i/o region
// ----------------------------------------------------------------
`define IRM_CORE_BASE     28'hFFFFC00
`define IRM_ID_OFF        24'hFFFF84
`define IRM_DEBUG_RAM_BASE_REGISTER_OFF     24'hFFFF90
`define IRM_DCR_OFF       24'hFFFFA0
`define IRM_BRK1_OFF      24'hFFFFB4
`define IRM_BRK2_OFF      24'hFFFFB8
`define IRM_BRK3_OFF      24'hFFFFBC
`define IRM_BRK4_OFF      24'hFFFFD0
`define IRM_BRK_RESET     24'h000000
`define IRM_DCR_RESET     8'h00
`define IRM_PROC_ID_DEF   32'h00A5_5A01

`endif

// File: hw/irm_map_pkg.sv
// types shared by the internal ram map block
package irm_map_pkg;

  // ----------------------------------------------------------------
  // one-hot decode of the region an access falls in
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    IRM_REG_NONE = 8'h01,
    IRM_REG_RAM  = 8'h02,
    IRM_REG_DISP = 8'h04,
    IRM_REG_P1   = 8'h08,
    IRM_REG_P2   = 8'h10,
    IRM_REG_SIZE = 8'h20,
    IRM_REG_KEY  = 8'h40,
    IRM_REG_CORE = 8'h80
  } irm_region_t;

  typedef logic [27:0] irm_addr_t;

endpackage : irm_map_pkg

// File: hw/irm_word_store.sv
// flip-flop word storage with byte strobes and two read ports
`timescale 1ns/1ps
module irm_word_store #(
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  input  wire logic              pclk,
  input  wire logic              wr_en,
  input  wire logic [3:0]        wr_strb,
  input  wire logic [IDX_W-1:0]  wr_idx,
  input  wire logic [31:0]       wr_data,
  input  wire logic [IDX_W-1:0]  rd_idx,
  output logic      [31:0]       rd_data,
  input  wire logic [IDX_W-1:0]  side_idx,
  output logic      [31:0]       side_data
);

  // ----------------------------------------------------------------
  // one write lane per byte, no reset: contents are data, not control
  // ----------------------------------------------------------------
  // each lane owns its own array so no two processes write one variable
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      logic [7:0] lane [DEPTH];
      always_ff @(posedge pclk) begin
        if (wr_en && wr_strb[b]) begin
          lane[wr_idx] <= wr_data[8*b +: 8];
        end
      end
      // out-of-range indexes read zero rather than x
      assign rd_data[8*b +: 8]   = (32'(rd_idx) < DEPTH) ? lane[rd_idx] : 8'h00;
      assign side_data[8*b +: 8] = (32'(side_idx) < DEPTH) ? lane[side_idx] : 8'h00;
    end
  endgenerate

endmodule : irm_word_store

// File: hw/irm_map_top.sv
// apb slave decoding internal ram, display memory, peripheral and core i/o regions
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "irm_map_cfg.svh"
module irm_map_top #(
  parameter logic [31:0] PROC_ID = `IRM_PROC_ID_DEF  // arbitrary value, not a real part code
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire irm_map_pkg::irm_addr_t   paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     display_active,
  input  wire logic [`IRM_DISP_IDX_W-1:0] disp_idx,
  output logic      [31:0]              disp_data,
  output logic                          periph1_sel,
  output logic                          periph2_sel,
  output logic                          periph_write,
  output logic                          periph_wide,
  output logic      [11:0]              periph_offset,
  output logic      [15:0]              periph_wdata,
  input  wire logic [15:0]              periph_rdata,
  output logic      [2:0]               ram_size_code,
  output logic                          debug_base_select,
  output logic      [23:0]              debug_ram_base,
  output logic                          ram_debug_tail
);
  import irm_map_pkg::*;

  // ----------------------------------------------------------------
  // fixed addresses
  // ----------------------------------------------------------------
  localparam irm_addr_t SIZE_ADDR = 28'(`IRM_SIZE_IDX * 4);
  localparam irm_addr_t KEY_ADDR  = 28'(`IRM_KEY_IDX * 4);
  localparam logic [23:0] BRK_OFF [4] = '{`IRM_BRK1_OFF, `IRM_BRK2_OFF,
                                          `IRM_BRK3_OFF, `IRM_BRK4_OFF};

  // control state
  logic [7:0]  config_write_key_register;
  logic [7:0]  debug_control_register;
  logic [23:0] instr_break_addr [4];

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_acc    = access_ph && pwrite;

  // ----------------------------------------------------------------
  // size limit from the current size code
  // ----------------------------------------------------------------
  irm_addr_t ram_limit;
  assign ram_limit = (ram_size_code == `IRM_SZ_2K) ? `IRM_RAM_LIM_2K :
                     (ram_size_code == `IRM_SZ_4K) ? `IRM_RAM_LIM_4K :
                     `IRM_RAM_LIM_8K;  // reserved codes keep the full array reachable

  // ----------------------------------------------------------------
  // region decode
  // ----------------------------------------------------------------
  logic hit_ram;
  logic hit_disp;
  logic hit_p1;
  logic hit_p2;
  logic hit_core;
  assign hit_ram  = paddr < ram_limit;
  assign hit_disp = (paddr >= `IRM_DISP_BASE) &&
                    (paddr < `IRM_DISP_BASE + `IRM_DISP_BYTES);
  assign hit_p1   = (paddr >= `IRM_P1_BASE) &&
                    (paddr < `IRM_P1_BASE + `IRM_P1_SIZE);
  assign hit_p2   = (paddr >= `IRM_P2_BASE) &&
                    (paddr < `IRM_P2_BASE + `IRM_P2_SIZE) && !hit_disp;
  assign hit_core = paddr >= `IRM_CORE_BASE;

  irm_region_t region;
  assign region = hit_ram            ? IRM_REG_RAM  :
                  hit_disp           ? IRM_REG_DISP :
                  hit_p1             ? IRM_REG_P1   :
                  hit_p2             ? IRM_REG_P2   :
                  (paddr == SIZE_ADDR) ? IRM_REG_SIZE :
                  (paddr == KEY_ADDR)  ? IRM_REG_KEY  :
                  hit_core           ? IRM_REG_CORE :
                  IRM_REG_NONE;

  // debugger-owned tail of the selected ram size, flagged for the debug unit
  assign ram_debug_tail = access_ph && hit_ram &&
                          (paddr >= ram_limit - `IRM_DBG_TAIL);

  // ----------------------------------------------------------------
  // embedded ram: write on the access edge, read registered at setup
  // ----------------------------------------------------------------
  logic        ram_we;
  logic [31:0] ram_rd;
  assign ram_we = wr_acc && (region == IRM_REG_RAM);

  irm_word_store #(
    .DEPTH (`IRM_RAM_WORDS),
    .IDX_W (`IRM_RAM_IDX_W)
  ) u_ram (
    .pclk      (pclk),
    .wr_en     (ram_we),
    .wr_strb   (pstrb),
    .wr_idx    (paddr[`IRM_RAM_IDX_W+1:2]),
    .wr_data   (pwdata),
    .rd_idx    (paddr[`IRM_RAM_IDX_W+1:2]),
    .rd_data   (ram_rd),
    .side_idx  ({`IRM_RAM_IDX_W{1'b0}}),
    .side_data ()
  );

  // ----------------------------------------------------------------
  // display memory: 16-bit lanes only, shared with the lcd read port
  // ----------------------------------------------------------------
  logic        disp_we;
  logic [31:0] disp_rd;
  logic [3:0]  disp_strb;
  logic [`IRM_DISP_IDX_W-1:0] disp_bus_idx;
  irm_addr_t   disp_off;
  assign disp_off     = paddr - `IRM_DISP_BASE;
  assign disp_bus_idx = disp_off[`IRM_DISP_IDX_W+1:2];
  // a 16-bit device: a byte strobe pulls in its whole halfword
  assign disp_strb = {{2{|pstrb[3:2]}}, {2{|pstrb[1:0]}}};
  // bus writes stay open while the lcd is idle; during display the lcd owns it
  assign disp_we = wr_acc && (region == IRM_REG_DISP) && !display_active;

  irm_word_store #(
    .DEPTH (`IRM_DISP_WORDS),
    .IDX_W (`IRM_DISP_IDX_W)
  ) u_disp (
    .pclk      (pclk),
    .wr_en     (disp_we),
    .wr_strb   (disp_strb),
    .wr_idx    (disp_bus_idx),
    .wr_data   (pwdata),
    .rd_idx    (disp_bus_idx),
    .rd_data   (disp_rd),
    .side_idx  (disp_idx),
    .side_data (disp_data)
  );

  // ----------------------------------------------------------------
  // peripheral port: offset within region and per-slot width
  // ----------------------------------------------------------------
  irm_addr_t p_off;
  logic      p1_wide;
  logic      p2_wide;
  logic [31:0] p1_mask;
  logic [31:0] p2_mask;
  assign p1_mask = `IRM_P1_WIDE;
  assign p2_mask = `IRM_P2_WIDE;
  assign p_off   = hit_p1 ? paddr - `IRM_P1_BASE : paddr - `IRM_P2_BASE;
  assign p1_wide = p1_mask[p_off[9:5]];   // 32-byte slots
  assign p2_wide = p2_mask[p_off[11:7]];  // 128-byte slots

  assign periph1_sel   = access_ph && (region == IRM_REG_P1);
  assign periph2_sel   = access_ph && (region == IRM_REG_P2);
  assign periph_write  = wr_acc && (periph1_sel || periph2_sel);
  assign periph_wide   = (region == IRM_REG_P1) ? p1_wide : p2_wide;
  assign periph_offset = p_off[11:0];
  // narrow slots never see the upper byte
  assign periph_wdata  = periph_wide ? pwdata[15:0] : {8'h00, pwdata[7:0]};

  logic [15:0] periph_rd;
  assign periph_rd = periph_wide ? periph_rdata : {8'h00, periph_rdata[7:0]};

  // ----------------------------------------------------------------
  // size register: key gated writes, fixed reserved fields
  // ----------------------------------------------------------------
  logic key_open;
  logic size_we;
  logic key_we;
  assign key_open = config_write_key_register == `IRM_KEY_VALUE;
  assign size_we  = wr_acc && (region == IRM_REG_SIZE) && key_open;
  assign key_we   = wr_acc && (region == IRM_REG_KEY) && pstrb[0];

  // key register is left open by software until it rewrites it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_write_key_register <= `IRM_KEY_RESET;
    end else if (key_we) begin
      config_write_key_register <= pwdata[7:0];
    end
  end

  // size code and debug base select, byte lane per field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_size_code     <= `IRM_SZ_RESET;
      debug_base_select <= `IRM_DBSEL_RESET;
    end else if (size_we) begin
      if (pstrb[0]) begin
        ram_size_code <= pwdata[`IRM_SZ_MSB:`IRM_SZ_LSB];
      end
      if (pstrb[1]) begin
        debug_base_select <= pwdata[`IRM_DBSEL_BIT];
      end
    end
  end

  assign debug_ram_base = debug_base_select ? `IRM_DBG_BASE_LO : `IRM_DBG_BASE_HI;

  logic [31:0] ram_size_register;
  always_comb begin
    ram_size_register = 32'h0000_0000;
    ram_size_register[`IRM_SZ_MSB:`IRM_SZ_LSB]   = ram_size_code;
    ram_size_register[`IRM_RSV_MSB:`IRM_RSV_LSB] = `IRM_RSV_VALUE;
    ram_size_register[`IRM_DBSEL_BIT]             = debug_base_select;
  end

  // ----------------------------------------------------------------
  // core i/o registers
  // ----------------------------------------------------------------
  logic [23:0] core_off;
  logic        core_wr;
  logic [3:0]  brk_hit;
  assign core_off = paddr[23:0];
  assign core_wr  = wr_acc && (region == IRM_REG_CORE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_control_register <= `IRM_DCR_RESET;
    end else if (core_wr && (core_off == `IRM_DCR_OFF) && pstrb[0]) begin
      debug_control_register <= pwdata[7:0];
    end
  end

  // one break address register per slot
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_brk
      assign brk_hit[i] = core_off == BRK_OFF[i];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          instr_break_addr[i] <= `IRM_BRK_RESET;
        end else if (core_wr && brk_hit[i]) begin
          instr_break_addr[i] <= pwdata[23:0];
        end
      end
    end
  endgenerate

  logic [31:0] core_rd;
  always_comb begin
    core_rd = 32'h0000_0000;  // unlisted core offsets read zero
    if (core_off == `IRM_ID_OFF) begin
      core_rd = PROC_ID;
    end else if (core_off == `IRM_DEBUG_RAM_BASE_REGISTER_OFF) begin
      core_rd = {8'h00, debug_ram_base};
    end else if (core_off == `IRM_DCR_OFF) begin
      core_rd = {24'h000000, debug_control_register};
    end
    for (int k = 0; k < 4; k++) begin
      if (brk_hit[k]) begin
        core_rd = {8'h00, instr_break_addr[k]};
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux, captured in setup so the access phase never waits
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;
  always_comb begin
    case (region)
      IRM_REG_RAM:  next_prdata = ram_rd;
      IRM_REG_DISP: next_prdata = disp_rd;
      IRM_REG_P1:   next_prdata = {16'h0000, periph_rd};
      IRM_REG_P2:   next_prdata = {16'h0000, periph_rd};
      IRM_REG_SIZE: next_prdata = ram_size_register;
      IRM_REG_KEY:  next_prdata = {24'h000000, config_write_key_register};
      IRM_REG_CORE: next_prdata = core_rd;
      default:      next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // every mapped region answers in the first access cycle
  assign pready  = 1'b1;
  assign pslverr = access_ph && (region == IRM_REG_NONE);

endmodule : irm_map_top

// File: sim/irm_map_top_sva.sv
// assertion checker for the internal ram map apb slave
`timescale 1ns/1ps
`include "irm_map_cfg.svh"
module irm_map_top_sva (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire irm_map_pkg::irm_addr_t paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   periph1_sel,
  input wire logic                   periph2_sel,
  input wire logic                   periph_wide,
  input wire logic [11:0]            periph_offset,
  input wire logic [2:0]             ram_size_code,
  input wire logic                   debug_base_select,
  input wire logic [23:0]            debug_ram_base,
  input wire logic                   ram_debug_tail
);
  import irm_map_pkg::*;

  // ----------------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------------
  localparam irm_addr_t SIZE_ADDR = 28'h0014C98;
  localparam irm_addr_t KEY_ADDR  = 28'h0014C90;
  logic [7:0] key_shadow;
  irm_addr_t  ram_limit;
  wire        acc     = psel && penable;
  wire        size_wr = acc && pwrite && (paddr == SIZE_ADDR);
  wire        in_disp = paddr >= `IRM_DISP_BASE && paddr < `IRM_DISP_BASE + `IRM_DISP_BYTES;
  // reserved codes keep the full 8 KB window
  assign ram_limit = (ram_size_code == 3'h2) ? `IRM_RAM_LIM_4K :
                     (ram_size_code == 3'h3) ? `IRM_RAM_LIM_2K : `IRM_RAM_LIM_8K;

  // shadow of the key register, not visible at the ports
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) key_shadow <= 8'h00;
    else if (acc && pwrite && paddr == KEY_ADDR && pstrb[0]) key_shadow <= pwdata[7:0];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_unlocked_wr;
    size_wr && pstrb[0] && key_shadow == `IRM_KEY_VALUE;
  endsequence
  sequence s_locked_wr;
    size_wr && key_shadow != `IRM_KEY_VALUE;
  endsequence

  property p_one_cycle;  acc |-> pready;  endproperty
  property p_ram_hit;  acc && paddr < ram_limit |-> !pslverr;  endproperty
  property p_over_limit;
    acc && paddr >= ram_limit && paddr < `IRM_P1_BASE |-> pslverr;
  endproperty
  property p_tail;
    acc && paddr < ram_limit |-> ram_debug_tail == (paddr >= ram_limit - `IRM_DBG_TAIL);
  endproperty
  property p_size_load;  s_unlocked_wr |=> ram_size_code == $past(pwdata[2:0]);  endproperty
  property p_locked;
    s_locked_wr |=> $stable(ram_size_code) && $stable(debug_base_select);
  endproperty
  property p_reset_vals;
    $rose(presetn) |-> ram_size_code == `IRM_SZ_RESET && debug_base_select == `IRM_DBSEL_RESET;
  endproperty
  property p_dbase;
    debug_ram_base == (debug_base_select ? `IRM_DBG_BASE_LO : `IRM_DBG_BASE_HI);
  endproperty
  property p_periph1;
    acc && paddr >= `IRM_P1_BASE && paddr < `IRM_P1_BASE + `IRM_P1_SIZE
      |-> periph1_sel && !periph2_sel && periph_offset == paddr[11:0];
  endproperty
  property p_periph2;
    acc && paddr >= `IRM_P2_BASE && paddr < `IRM_P2_BASE + `IRM_P2_SIZE && !in_disp
      |-> periph2_sel && !periph1_sel;
  endproperty
  property p_width;
    periph1_sel || periph2_sel
      |-> periph_wide == (periph1_sel ? periph_offset >= 12'h100 : periph_offset >= 12'h300);
  endproperty
  property p_core;  acc && paddr >= `IRM_CORE_BASE |-> !pslverr;  endproperty

  a_one_cycle: assert property (p_one_cycle) else $error("access not ended in one cycle");
  a_ram_hit: assert property (p_ram_hit) else $error("ram access flagged as error");
  a_over_limit: assert property (p_over_limit) else $error("access above limit accepted");
  a_tail: assert property (p_tail) else $error("debug tail flag wrong");
  a_size_load: assert property (p_size_load) else $error("unlocked size write lost");
  a_locked: assert property (p_locked) else $error("locked size write took effect");
  a_reset_vals: assert property (p_reset_vals) else $error("size reg reset value wrong");
  a_dbase: assert property (p_dbase) else $error("debug base mismatch");
  a_periph1: assert property (p_periph1) else $error("region 1 decode wrong");
  a_periph2: assert property (p_periph2) else $error("region 2 decode wrong");
  a_width: assert property (p_width) else $error("slot width wrong");
  a_core: assert property (p_core) else $error("core area access errored");
endmodule : irm_map_top_sva

bind irm_map_top irm_map_top_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .periph1_sel(periph1_sel), .periph2_sel(periph2_sel), .periph_wide(periph_wide),
  .periph_offset(periph_offset), .ram_size_code(ram_size_code),
  .debug_base_select(debug_base_select), .debug_ram_base(debug_ram_base),
  .ram_debug_tail(ram_debug_tail)
);

// File: sim/irm_periph_model.sv
// peripheral slot responder standing behind the two decoded regions
`timescale 1ns/1ps
module irm_periph_model (
  input  wire logic        periph_wide,
  input  wire logic [11:0] periph_offset,
  output logic      [15:0] periph_rdata
);
  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data follows the offset so a decode slip shows; narrow slots put
  // junk on the upper byte because the bus must ignore it there
  assign periph_rdata = periph_wide ? {4'hC, periph_offset} :
                        {~{4'hC, periph_offset[11:8]}, periph_offset[7:0]};
endmodule : irm_periph_model

// File: sim/irm_map_top_bench.sv
// self-checking bench for the internal ram map apb slave
`timescale 1ns/1ps
`include "irm_map_cfg.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module irm_map_top_bench;
  import irm_map_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, display_active;
  irm_addr_t   paddr;
  logic [31:0] pwdata, prdata, disp_data, rdat;
  logic [3:0]  pstrb, disp_idx;
  logic        pready, pslverr, periph1_sel, periph2_sel, periph_write, periph_wide;
  logic [11:0] periph_offset;
  logic [15:0] periph_wdata, periph_rdata;
  logic [2:0]  ram_size_code;
  logic        debug_base_select, ram_debug_tail, rerr, c_sel1, c_sel2, c_wide;
  logic        c_tail, c_pwr;
  logic [15:0] c_wdata;
  irm_addr_t   brk_a [4] = '{28'hFFFFFB4, 28'hFFFFFB8, 28'hFFFFFBC, 28'hFFFFFD0};
  logic [23:0] debug_ram_base;
  int          miscompares = 0;
  int          n_compared = 0;
  localparam irm_addr_t SIZE_A = 28'h0014C98;
  localparam irm_addr_t KEY_A  = 28'h0014C90;

  irm_map_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .display_active(display_active),
    .disp_idx(disp_idx), .disp_data(disp_data), .periph1_sel(periph1_sel),
    .periph2_sel(periph2_sel), .periph_write(periph_write), .periph_wide(periph_wide),
    .periph_offset(periph_offset), .periph_wdata(periph_wdata),
    .periph_rdata(periph_rdata), .ram_size_code(ram_size_code),
    .debug_base_select(debug_base_select), .debug_ram_base(debug_ram_base),
    .ram_debug_tail(ram_debug_tail));
  irm_periph_model u_periph (.periph_wide(periph_wide), .periph_offset(periph_offset),
    .periph_rdata(periph_rdata));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // one apb transfer; result and region strobes taken at the ready edge
  task automatic apb(input logic wr, input irm_addr_t a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      report_and_stop;
    end
    rdat = prdata; rerr = pslverr; c_sel1 = periph1_sel; c_sel2 = periph2_sel;
    c_wide = periph_wide;
    c_tail = ram_debug_tail;
    c_pwr = periph_write;
    c_wdata = periph_wdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input irm_addr_t a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input irm_addr_t a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; pstrb = 4'h0; display_active = 1'b0; disp_idx = 4'h1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // reset layout of the size register
    rd(SIZE_A); `CHK(rdat, 32'h0000_0011)
    `CHK(debug_ram_base, 24'hFFC00)
    // locked: write ignored
    wr(SIZE_A, 32'h0000_0103); rd(SIZE_A); `CHK(rdat, 32'h0000_0011)
    // ram at both ends, with an idle cycle between transfers
    wr(28'h0, 32'hA5A5_0001); wr(28'h1FFC, 32'h5A5A_1FFC);
    rd(28'h0); `CHK(rdat, 32'hA5A5_0001)
    rd(28'h1FFC); `CHK(rdat, 32'h5A5A_1FFC)
    `CHK(rerr, 1'b0)
    rd(28'h2000); `CHK(rerr, 1'b1)
    // unlock, then step the size codes down to 2 KB
    wr(KEY_A, 32'h96);
    wr(SIZE_A, 32'h0000_0002); rd(28'h1000); `CHK(rerr, 1'b1)
    rd(28'h0FFC); `CHK(rerr, 1'b0)
    wr(SIZE_A, 32'h0000_0103); rd(SIZE_A); `CHK(rdat, 32'h0000_0113)
    `CHK(debug_ram_base, 24'h00000)
    rd(28'h0800); `CHK(rerr, 1'b1)
    rd(28'h07C0); `CHK({rerr, c_tail}, 2'h1)
    // every bit set: reserved bits keep their fixed values
    wr(SIZE_A, 32'hFFFF_FFFF); rd(SIZE_A); `CHK(rdat, 32'h0000_0117)
    wr(SIZE_A, 32'h0000_0001); rd(SIZE_A); `CHK(rdat, 32'h0000_0011)
    wr(KEY_A, 32'h00);
    rd(28'h1FC0); `CHK({rerr, c_tail}, 2'h1)
    // display memory as storage, writes dropped while the lcd uses it
    wr(28'h53C4, 32'h1234_5678); rd(28'h53C4); `CHK(rdat, 32'h1234_5678)
    `CHK(disp_data, 32'h1234_5678)
    display_active <= 1'b1;
    wr(28'h53C4, 32'hDEAD_BEEF); rd(28'h53C4); `CHK(rdat, 32'h1234_5678)
    display_active <= 1'b0;
    // peripheral regions and slot widths
    rd(28'h4004); `CHK({c_sel1, c_wide, rdat[15:0]}, 18'h20004)
    rd(28'h4100); `CHK({c_sel1, c_wide, rdat[15:0]}, 18'h3C100)
    rd(28'h5010); `CHK({c_sel2, c_wide, rdat[15:0]}, 18'h20010)
    // narrow slots never see the upper write byte
    wr(28'h4004, 32'h0000_ABCD); `CHK({c_pwr, c_wdata}, 17'h100CD)
    wr(28'h4100, 32'h0000_ABCD); `CHK({c_pwr, c_wdata}, 17'h1ABCD)
    rd(28'h5304); `CHK({c_sel2, c_wide, rdat[15:0]}, 18'h3C304)
    // core i/o registers
    rd(28'hFFFFC00); `CHK({rerr, rdat}, 33'h0)
    rd(28'hFFFFF84); `CHK(rdat, `IRM_PROC_ID_DEF)
    rd(28'hFFFFF90); `CHK(rdat, 32'h000F_FC00)
    wr(28'hFFFFFA0, 32'hFFFF_FFFF); rd(28'hFFFFFA0); `CHK(rdat, 32'h0000_00FF)
    foreach (brk_a[i]) begin
      wr(brk_a[i], 32'hFFAB_CDE0 + i);
    end
    foreach (brk_a[i]) begin
      rd(brk_a[i]); `CHK(rdat, 32'h00AB_CDE0 + i)
    end
    report_and_stop;
  end
endmodule : irm_map_top_bench
